// File: pkg/eer_pkg.sv
package eer_pkg;
   localparam logic [3:0] ARRAY_TYPE_CODE  = 4'ha;         // 1010b
   localparam logic [3:0] ID_TYPE_CODE     = 4'hb;         // 1011b
   localparam int         ARRAY_ADDR_W     = 16;
   localparam int         PAGE_OFS_W       = 7;            // 128-byte pages
   localparam int         ID_OFS_W         = 7;            // 128-byte identification page
   localparam int         ID_READ_OFS_W    = 6;            // offset bits taken on id reads
   localparam int         LOCK_SEL_POS     = 10;           // id_lock_select_bit
   localparam int         LOCK_DATA_POS    = 1;
   localparam int         BIT_CNT_W        = 4;
   localparam logic [3:0] LAST_DATA_BIT    = 4'h7;
   localparam logic [3:0] ACK_BIT          = 4'h8;
   localparam int         CLK_MHZ          = 100;
   localparam int         SCL_HALF_NS      = 500;          // Three ticks a bit: about 667 kHz
   localparam int         SCL_HALF_CYC     = SCL_HALF_NS * CLK_MHZ / 1000;
endpackage : eer_pkg

// File: pkg/eer_if.sv
interface eer_if;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   // Open-drain wire: low when any enabled driver pulls low
   logic sda;
   logic scl;
   assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
   assign scl = !(scl_oe && !scl_o);
   modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (input scl, input sda, output scl_o, output scl_oe,
                 output sda_host_o, output sda_host_oe);
endinterface : eer_if

// File: src/eer_fifo.sv
module eer_fifo
   import eer_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp, rp, next_wp, next_rp;
   logic             do_wr, do_rd;

   assign in_ready  = (wp - rp) != (AW+1)'(DEPTH);
   assign out_valid = wp != rp;
   assign out_data  = mem[rp[AW-1:0]];
   always_comb begin
      do_wr   = in_valid && in_ready;
      do_rd   = out_valid && out_ready;
      next_wp = wp + (AW+1)'(do_wr);
      next_rp = rp + (AW+1)'(do_rd);
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
      if (do_wr) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end
endmodule : eer_fifo

// File: src/eer_dev.sv
// Summary of operation
// - Read uses write header, direction bit one
// - Address counter holds last access plus one
// - Reads wrap last array byte to first
// - Writes wrap within current page only
// - After read header, shift current byte MSB first
// - Master nacks then stops single-byte read
// - Random read starts with dummy address write
// - Repeated start then read header follows
// - Master ack advances counter, next byte
// - Nack then stop ends read, release line
// - Separate lockable 128-byte identification page
// - Identification reads use type code 1011b
// - Id reads take offset from six bits
// - Master stays inside identification page
// - Lock: byte write, type 1011b, select bit one
// - Lock data byte needs bit one set
// - Lock stays set; only srst clears it
// - Header 1010, select straps, direction last
// - Ack by pulling data low ninth clock
// - Select mismatch: no ack, go idle
// - Locked page nacks identification write data
module eer_dev
   import eer_pkg::*;
#(
   parameter int MEM_BYTES = 65536
) (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic [2:0] chip_select_straps,
   eer_if.dev              bus,
   output logic            id_locked
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, ST_HDR = 6'h02, ST_AHI = 6'h04,
      ST_ALO  = 6'h08, ST_WDAT = 6'h10, ST_RDAT = 6'h20
   } eer_dev_st_e;

   logic [7:0] mem    [MEM_BYTES];
   logic [7:0] id_mem [2**ID_OFS_W];

   logic [2:0] scl_s, sda_s;
   logic       scl_rise, scl_fall, start_c, stop_c;
   always_ff @(posedge mclk) begin
      if (srst) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else begin
         scl_s <= {scl_s[1:0], bus.scl};
         sda_s <= {sda_s[1:0], bus.sda};
      end
   end
   always_comb begin
      scl_rise = scl_s[1] && !scl_s[2];
      scl_fall = !scl_s[1] && scl_s[2];
      start_c  = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
      stop_c   = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
   end

   ////////////////////////////////////////////////////////////////////////////
   eer_dev_st_e               st, next_st;
   logic [BIT_CNT_W-1:0]      bcnt, next_bcnt;
   logic [7:0]                sh, next_sh;
   logic [ARRAY_ADDR_W-1:0]   cnt, next_cnt, aw, next_aw;
   logic                      id_sel, next_id_sel, ack, next_ack, drv, next_drv;
   logic                      next_locked, wr_en;
   logic [7:0]                wdat;
   logic [ARRAY_ADDR_W-1:0]   waddr;

   function automatic logic [ARRAY_ADDR_W-1:0] page_inc(input logic [ARRAY_ADDR_W-1:0] a);
      page_inc = {a[ARRAY_ADDR_W-1:PAGE_OFS_W], a[PAGE_OFS_W-1:0] + 7'h01};
   endfunction : page_inc

   // Id reads use only the six offset bits; bit six ignored
   function automatic logic [ID_OFS_W-1:0] id_rd_ofs(input logic [ARRAY_ADDR_W-1:0] a);
      id_rd_ofs = {1'b0, a[ID_READ_OFS_W-1:0]};
   endfunction : id_rd_ofs

   always_comb begin
      next_st = st;  next_bcnt = bcnt;  next_sh = sh;  next_cnt = cnt;
      next_aw = aw;  next_id_sel = id_sel;  next_ack = ack;  next_drv = drv;
      next_locked = id_locked;  wr_en = 1'b0;  wdat = sh;  waddr = cnt;
      if (start_c) begin
         // The start's own falling clock must bring the count to zero
         next_st = ST_HDR;  next_bcnt = '1;  next_ack = 1'b0;  next_drv = 1'b0;
      end else if (stop_c) begin
         next_st = ST_IDLE;  next_ack = 1'b0;  next_drv = 1'b0;
      end else if (scl_rise && st != ST_IDLE) begin
         if (bcnt <= LAST_DATA_BIT) begin
            // Read bytes shift out on the falling clock only
            if (st != ST_RDAT) next_sh = {sh[6:0], sda_s[1]};
         end else if (st == ST_RDAT && !ack) begin
            // Counter moves past every byte read, acked or not
            next_cnt = cnt + 16'h0001;
            if (sda_s[1]) next_st = ST_IDLE;
         end
      end else if (scl_fall && st != ST_IDLE) begin
         next_bcnt = bcnt + 4'h1;
         next_ack  = 1'b0;
         next_drv  = 1'b0;
         if (bcnt == LAST_DATA_BIT && st != ST_RDAT) begin
            next_ack = 1'b1;
            case (st)
               ST_HDR: begin
                  next_id_sel = sh[7:4] == ID_TYPE_CODE;
                  if ((sh[7:4] != ARRAY_TYPE_CODE && sh[7:4] != ID_TYPE_CODE)
                      || sh[3:1] != chip_select_straps) begin
                     next_ack = 1'b0;
                     next_st  = ST_IDLE;
                  end
                  else if (sh[0]) next_st = ST_RDAT;
                  else next_st = ST_AHI;
               end
               ST_AHI: begin
                  next_aw[15:8] = sh;
                  next_st = ST_ALO;
               end
               ST_ALO: begin
                  next_aw[7:0] = sh;
                  next_cnt = {aw[15:8], sh};
                  next_st = ST_WDAT;
               end
               ST_WDAT: begin
                  if (id_sel && id_locked) begin
                     next_ack = 1'b0;
                  end else if (id_sel && aw[LOCK_SEL_POS]) begin
                     if (sh[LOCK_DATA_POS]) next_locked = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     next_cnt = page_inc(cnt);
                  end
               end
               default: next_st = ST_IDLE;
            endcase
         end else if (bcnt == ACK_BIT) begin
            next_bcnt = '0;
         end
         if (next_st == ST_RDAT && next_bcnt <= LAST_DATA_BIT) begin
            next_sh  = (next_bcnt == '0)
                       ? (id_sel ? id_mem[id_rd_ofs(next_cnt)] : mem[next_cnt]) : sh;
            next_drv = 1'b1;
            if (next_bcnt != '0) next_sh = {sh[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= ST_IDLE;  bcnt <= '0;  sh <= '0;  cnt <= '0;  aw <= '0;
         id_sel <= 1'b0;  ack <= 1'b0;  drv <= 1'b0;  id_locked <= 1'b0;
      end else begin
         st <= next_st;  bcnt <= next_bcnt;  sh <= next_sh;  cnt <= next_cnt;
         aw <= next_aw;  id_sel <= next_id_sel;  ack <= next_ack;  drv <= next_drv;
         id_locked <= next_locked;
      end
      if (wr_en && id_sel) id_mem[waddr[ID_OFS_W-1:0]] <= wdat;
      else if (wr_en) mem[waddr] <= wdat;
   end

   // MSB of the shifter goes out; open drain only ever pulls low
   assign bus.sda_dev_o  = 1'b0;
   assign bus.sda_dev_oe = ack || (drv && !sh[7]);
endmodule : eer_dev

// File: src/eer_host.sv
module eer_host
   import eer_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic [7:0] cmd_byte,
   input  wire logic [1:0] cmd_kind,
   input  wire logic       cmd_last,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   input  wire logic       rd_ready,
   output logic            nack_seen,
   eer_if.host             bus
);
   // cmd_kind: 0 start+write byte, 1 write byte, 2 read byte, 3 stop
   typedef enum logic [4:0] {
      H_IDLE = 5'h01, H_START = 5'h02, H_BIT = 5'h04, H_STOP = 5'h08, H_PUSH = 5'h10
   } eer_host_st_e;

   eer_host_st_e st, next_st;
   logic [15:0]  div, next_div;
   logic [1:0]   ph, next_ph;
   logic [3:0]   bcnt, next_bcnt;
   logic [8:0]   sh, next_sh;
   logic         rd, next_rd, last, next_last, sclo, next_sclo, sdao, next_sdao;
   logic         next_nack, tick, f_valid, f_ready;
   logic [1:0]   sda_s;

   always_ff @(posedge mclk) begin
      if (srst) sda_s <= 2'h3;
      else sda_s <= {sda_s[0], bus.sda};
   end

   eer_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
      .mclk(mclk), .srst(srst), .in_data(sh[8:1]), .in_valid(f_valid),
      .in_ready(f_ready), .out_data(rd_data), .out_valid(rd_valid), .out_ready(rd_ready)
   );

   always_comb begin
      tick = div == 16'(SCL_HALF_CYC - 1);
      next_div = tick ? 16'h0000 : div + 16'h0001;
      next_st = st;  next_ph = ph;  next_bcnt = bcnt;  next_sh = sh;  next_rd = rd;
      next_last = last;  next_sclo = sclo;  next_sdao = sdao;  next_nack = nack_seen;
      cmd_ready = st == H_IDLE;  f_valid = 1'b0;
      case (st)
         H_IDLE: if (cmd_valid) begin
            next_rd = cmd_kind == 2'h2;
            next_last = cmd_last;
            // Master acks read bytes except the last
            next_sh = next_rd ? {8'hff, cmd_last} : {cmd_byte, 1'b1};
            next_bcnt = '0;  next_ph = '0;
            if (cmd_kind == 2'h0) next_st = H_START;
            else if (cmd_kind == 2'h3) next_st = H_STOP;
            else next_st = H_BIT;
         end
         H_START: if (tick) begin
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: begin next_sdao = 1'b1; next_sclo = 1'b1; end
               2'h1: next_sdao = 1'b0;
               default: begin next_sclo = 1'b0; next_st = H_BIT; next_ph = '0; end
            endcase
         end
         H_BIT: if (tick) begin
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: next_sdao = sh[8];
               2'h1: next_sclo = 1'b1;
               default: begin
                  next_sclo = 1'b0;  next_ph = '0;
                  next_sh = {sh[7:0], sda_s[1]};
                  if (bcnt == ACK_BIT) begin
                     next_st = rd ? H_PUSH : H_IDLE;
                     if (!rd) next_nack = sda_s[1];
                  end
                  next_bcnt = bcnt + 4'h1;
               end
            endcase
         end
         H_PUSH: begin
            f_valid = 1'b1;
            if (f_ready) next_st = H_IDLE;
            next_sh = f_ready ? sh : sh;
         end
         H_STOP: if (tick) begin
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: next_sdao = 1'b0;
               2'h1: next_sclo = 1'b1;
               default: begin next_sdao = 1'b1; next_st = H_IDLE; next_ph = '0; end
            endcase
         end
         default: next_st = H_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= H_IDLE;  div <= '0;  ph <= '0;  bcnt <= '0;  sh <= '0;  rd <= 1'b0;
         last <= 1'b0;  sclo <= 1'b1;  sdao <= 1'b1;  nack_seen <= 1'b0;
      end else begin
         st <= next_st;  div <= next_div;  ph <= next_ph;  bcnt <= next_bcnt;
         sh <= next_sh;  rd <= next_rd;  last <= next_last;  sclo <= next_sclo;
         sdao <= next_sdao;  nack_seen <= next_nack;
      end
   end

   // Byte shifted into sh[8:1] after ninth bit holds read data
   assign bus.scl_o       = 1'b0;
   assign bus.scl_oe      = !sclo;
   assign bus.sda_host_o  = 1'b0;
   assign bus.sda_host_oe = !sdao;
endmodule : eer_host

// File: dv/eer_checker.sv
module eer_checker
   import eer_pkg::*;
(
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic [2:0] chip_select_straps,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       scl_o,
   input wire logic       scl_oe,
   input wire logic       sda_host_o,
   input wire logic       sda_host_oe,
   input wire logic       sda_dev_o,
   input wire logic       sda_dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic       scl_q, sda_q;
   logic [3:0] bit_n, next_bit_n;
   logic [1:0] byte_n, next_byte_n;
   logic [7:0] shreg, next_shreg, hdr, next_hdr;
   wire start_c = scl_q && scl && sda_q && !sda;
   wire stop_c  = scl_q && scl && !sda_q && sda;
   wire rise    = scl && !scl_q;
   wire ninth   = rise && (bit_n == ACK_BIT);
   function automatic logic hit(input logic [7:0] h, input logic [2:0] cs);
      return (h[7:4] == ARRAY_TYPE_CODE || h[7:4] == ID_TYPE_CODE) && h[3:1] == cs;
   endfunction : hit
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_bit_n = bit_n;
      next_byte_n = byte_n;
      next_shreg = shreg;
      next_hdr = hdr;
      if (start_c || stop_c) begin
         next_bit_n = 4'h0;
         next_byte_n = 2'h0;
      end else if (ninth) begin
         next_bit_n = 4'h0;
         if (byte_n == 2'h0) next_hdr = shreg;
         if (byte_n != 2'h3) next_byte_n = byte_n + 2'h1;
      end else if (rise) begin
         next_shreg = {shreg[6:0], sda};
         next_bit_n = bit_n + 4'h1;
      end
   end
   always_ff @(posedge mclk) begin
      scl_q <= srst ? 1'b1 : scl;
      sda_q <= srst ? 1'b1 : sda;
      bit_n <= srst ? 4'h0 : next_bit_n;
      byte_n <= srst ? 2'h0 : next_byte_n;
      shreg <= next_shreg;
      hdr <= next_hdr;
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_stop;
      stop_c;
   endsequence
   property p_hdr_ack;
      ninth && byte_n == 2'h0 |-> sda == !hit(shreg, chip_select_straps);
   endproperty
   a_hdr_ack: assert property (p_hdr_ack) else $error("header ack wrong");
   property p_data_ack;
      ninth && byte_n != 2'h0 && hit(hdr, chip_select_straps) && !hdr[0]
         && hdr[7:4] == ARRAY_TYPE_CODE |-> !sda;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("write byte not acked");
   property p_read_release;
      ninth && byte_n != 2'h0 && hdr[0] |-> !sda_dev_oe;
   endproperty
   a_read_release: assert property (p_read_release) else $error("dev drives ack slot");
   property p_dev_od;
      sda_dev_oe |-> !sda_dev_o;
   endproperty
   a_dev_od: assert property (p_dev_od) else $error("dev drives high");
   property p_host_od;
      (sda_host_oe |-> !sda_host_o) and (scl_oe |-> !scl_o);
   endproperty
   a_host_od: assert property (p_host_od) else $error("host drives high");
   property p_dev_scl_low;
      $changed(sda_dev_oe) |-> !scl;
   endproperty
   a_dev_scl_low: assert property (p_dev_scl_low) else $error("dev moves sda, scl high");
   property p_start_free;
      start_c |-> !sda_dev_oe;
   endproperty
   a_start_free: assert property (p_start_free) else $error("dev holds sda at start");
   property p_stop_release;
      s_stop |=> !sda_dev_oe [*8];
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("dev drives after stop");
endmodule : eer_checker

// File: dv/serial_eeprom_read_and_id_lock_test.sv
module serial_eeprom_read_and_id_lock_test
   import eer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, srst, cmd_last, cmd_valid, cmd_ready, rd_valid, rd_ready;
   logic        nack_seen, id_locked;
   logic [1:0]  cmd_kind;
   logic [2:0]  straps, bad;
   logic [7:0]  cmd_byte, rd_data, a_hi, a_lo, d0, d1, r;
   logic [31:0] seed;
   int          n_fail, tests_run;
   eer_if eer_if_i ();
   eer_dev eer_dev_i (.mclk(mclk), .srst(srst), .chip_select_straps(straps), .bus(eer_if_i.dev),
                      .id_locked(id_locked));
   eer_host eer_host_i (.mclk(mclk), .srst(srst), .cmd_byte(cmd_byte), .cmd_kind(cmd_kind),
                        .cmd_last(cmd_last), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
                        .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
                        .nack_seen(nack_seen), .bus(eer_if_i.host));
   eer_checker eer_checker_i (.mclk(mclk), .srst(srst), .chip_select_straps(straps),
      .scl(eer_if_i.scl), .sda(eer_if_i.sda), .scl_o(eer_if_i.scl_o),
      .scl_oe(eer_if_i.scl_oe), .sda_host_o(eer_if_i.sda_host_o),
      .sda_host_oe(eer_if_i.sda_host_oe), .sda_dev_o(eer_if_i.sda_dev_o),
      .sda_dev_oe(eer_if_i.sda_dev_oe));
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   task rnd(output logic [7:0] v);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      v = seed[7:0];
   endtask : rnd
   function automatic logic [7:0] hdr_b(input logic [3:0] t, input logic [2:0] cs, input logic d);
      return {t, cs, d};
   endfunction : hdr_b
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Holds the request until ready is seen, then waits for the host to go idle
   task send(input logic [1:0] kind, input logic [7:0] b, input logic last);
      int n;
      @(negedge mclk);
      cmd_kind = kind;
      cmd_byte = b;
      cmd_last = last;
      cmd_valid = 1'b1;
      n = 0;
      do begin @(posedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 100);
      @(negedge mclk);
      cmd_valid = 1'b0;
      do begin @(negedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 20000);
      chk("cmd_ready", 8'h01, {7'h0, cmd_ready});
   endtask : send
   task rd(input logic last, input logic [7:0] exp);
      int n;
      send(2'd2, 8'h00, last);
      n = 0;
      while (rd_valid !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
      chk("rd_data", exp, rd_data);
      rd_ready = 1'b1;
      @(negedge mclk);
      rd_ready = 1'b0;
   endtask : rd
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge mclk);
      n_fail++;
      $display("[ERR] watchdog expected done seen hang");
      tally_and_finish();
   end
   initial begin
      {mclk, cmd_byte, cmd_kind, cmd_last, cmd_valid, rd_ready, n_fail, tests_run} = '0;
      srst = 1'b1;
      seed = 32'h0d164bbf;
      rnd(r);
      straps = r[2:0];
      rnd(a_hi);
      rnd(a_lo);
      a_lo = a_lo | 8'h7e; // Last two bytes of a page
      rnd(d0);
      rnd(d1);
      repeat (6) @(posedge mclk);
      @(negedge mclk) srst = 1'b0;
      send(2'd0, hdr_b(ARRAY_TYPE_CODE, straps, 1'b0), 1'b0);
      chk("nack_seen", 8'h00, {7'h0, nack_seen});
      send(2'd1, a_hi, 1'b0);
      send(2'd1, a_lo, 1'b0);
      send(2'd1, d0, 1'b0);
      send(2'd1, d1, 1'b0);
      chk("nack_seen", 8'h00, {7'h0, nack_seen});
      send(2'd3, 8'h00, 1'b0);
      $display("test write done");
      send(2'd0, hdr_b(ARRAY_TYPE_CODE, straps, 1'b0), 1'b0);
      send(2'd1, a_hi, 1'b0);
      send(2'd1, a_lo, 1'b0);
      send(2'd0, hdr_b(ARRAY_TYPE_CODE, straps, 1'b1), 1'b0);
      rd(1'b0, d0);
      rd(1'b1, d1);
      send(2'd3, 8'h00, 1'b0);
      $display("test read done");
      rnd(r);
      bad = straps ^ (r[2:0] | 3'h1);
      send(2'd0, hdr_b(ARRAY_TYPE_CODE, bad, 1'b1), 1'b0);
      chk("nack_seen", 8'h01, {7'h0, nack_seen});
      send(2'd3, 8'h00, 1'b0);
      $display("test select done");
      rnd(d1);
      send(2'd0, hdr_b(ID_TYPE_CODE, straps, 1'b0), 1'b0);
      send(2'd1, 8'h00, 1'b0);
      send(2'd1, a_lo & 8'h3f, 1'b0);
      send(2'd1, d1, 1'b0);
      chk("nack_seen", 8'h00, {7'h0, nack_seen});
      send(2'd3, 8'h00, 1'b0);
      send(2'd0, hdr_b(ID_TYPE_CODE, straps, 1'b0), 1'b0);
      send(2'd1, 8'hfb, 1'b0);
      send(2'd1, a_lo | 8'hc0, 1'b0);
      send(2'd0, hdr_b(ID_TYPE_CODE, straps, 1'b1), 1'b0);
      rd(1'b1, d1);
      send(2'd3, 8'h00, 1'b0);
      $display("test identification_page done");
      chk("id_locked", 8'h00, {7'h0, id_locked});
      send(2'd0, hdr_b(ID_TYPE_CODE, straps, 1'b0), 1'b0);
      rnd(r);
      send(2'd1, r | (8'h01 << (LOCK_SEL_POS - 8)), 1'b0);
      send(2'd1, a_lo, 1'b0);
      rnd(r);
      send(2'd1, r | (8'h01 << LOCK_DATA_POS), 1'b0);
      send(2'd3, 8'h00, 1'b0);
      chk("id_locked", 8'h01, {7'h0, id_locked});
      send(2'd0, hdr_b(ID_TYPE_CODE, straps, 1'b0), 1'b0);
      send(2'd1, 8'h00, 1'b0);
      send(2'd1, a_lo, 1'b0);
      send(2'd1, d0, 1'b0);
      chk("nack_seen", 8'h01, {7'h0, nack_seen});
      send(2'd3, 8'h00, 1'b0);
      $display("test lock done");
      tally_and_finish();
   end
endmodule : serial_eeprom_read_and_id_lock_test
